// ### ifsto_defs.vh
// Purpose: constants for the IF speed-up timeout and test output select block
// Assumes: byte addresses on the plain register port, one 32-bit word each
// Notes: definitions only
`ifndef IFSTO_DEFS_VH
`define IFSTO_DEFS_VH

// register byte addresses
`define IFSTO_ADDR_W 8
`define IFSTO_REG_TIMEOUT 8'h00
`define IFSTO_REG_PUMP 8'h04
`define IFSTO_REG_SELECT 8'h08
`define IFSTO_REG_STATUS 8'h0c

// timeout field
`define IFSTO_TO_W 12
`define IFSTO_TO_RST 12'h000
`define IFSTO_TO_HIZ 12'h000
`define IFSTO_TO_MANUAL 12'h001
`define IFSTO_TO_GPO_LOW 12'h002
`define IFSTO_TO_GPO_HIGH 12'h003
`define IFSTO_TO_AUTO_MIN 12'h004

// pump gain register
`define IFSTO_PUMP_GAIN_BIT 0
`define IFSTO_PUMP_RST 1'b0

// select register: lower pair and upper pair
`define IFSTO_SEL_LO_LSB 0
`define IFSTO_SEL_HI_LSB 2
`define IFSTO_SEL_RST 2'h0

// status register fields
`define IFSTO_ST_TO_LSB 0
`define IFSTO_ST_PEND 12
`define IFSTO_ST_RUN 13
`define IFSTO_ST_DONE 14
`define IFSTO_ST_PUMP 15
`define IFSTO_ST_PIN_OE 16
`define IFSTO_ST_PIN_OUT 17

// test output select codes
`define IFSTO_MUX_HIZ 4'h0
`define IFSTO_MUX_HIGH 4'h1
`define IFSTO_MUX_LOW 4'h2
`define IFSTO_MUX_DLD_BOTH 4'h3
`define IFSTO_MUX_DLD_RF 4'h4
`define IFSTO_MUX_DLD_IF 4'h5
`define IFSTO_MUX_ALD_OD_BOTH 4'h6
`define IFSTO_MUX_ALD_OD_RF 4'h7
`define IFSTO_MUX_ALD_OD_IF 4'h8
`define IFSTO_MUX_ALD_PP_BOTH 4'h9
`define IFSTO_MUX_ALD_PP_RF 4'ha
`define IFSTO_MUX_ALD_PP_IF 4'hb
`define IFSTO_MUX_IF_REF 4'hc
`define IFSTO_MUX_IF_FB 4'hd
`define IFSTO_MUX_RF_REF 4'he
`define IFSTO_MUX_RF_FB 4'hf

`endif

// ### ifsto_sync.v
// Purpose: two-flop synchroniser for a group of asynchronous levels
// Assumes: one system clock, synchronous active-low reset
// Notes: only the second stage may be read by other logic
module ifsto_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input wire i_sys_clk,
  input wire i_rst_n,
  // levels
  input wire [WIDTH-1:0] i_async,
  output reg [WIDTH-1:0] o_sync
);

reg [WIDTH-1:0] meta;

always @(posedge i_sys_clk) begin
  if (!i_rst_n) begin
    meta <= {WIDTH{1'b0}};
    o_sync <= {WIDTH{1'b0}};
  end else begin
    meta <= i_async;
    o_sync <= meta;
  end
end

endmodule // ifsto_sync

// ### ifsto_halve.v
// Purpose: divide a synchronised divider output by two
// Assumes: input already synchronised, far slower than the system clock
// Notes: toggles on every rising edge of the input
module ifsto_halve (
  // clock and reset
  input wire i_sys_clk,
  input wire i_rst_n,
  // divider level in, halved level out
  input wire i_level,
  output reg o_half,
  output reg o_rise
);

reg prev;

always @(posedge i_sys_clk) begin
  if (!i_rst_n) begin
    prev <= 1'b0;
    o_half <= 1'b0;
    o_rise <= 1'b0;
  end else begin
    prev <= i_level;
    o_rise <= i_level & ~prev;
    if (i_level & ~prev) begin
      o_half <= ~o_half;
    end
  end
end

endmodule // ifsto_halve

// ### ifsto_top.v
// Purpose: IF speed-up timeout control and multifunction test pin select
// Assumes: 200 MHz system clock; all pin-side inputs are asynchronous
// Notes: phase-detector events are rising edges of i_if_pfd after sync
//
// How it works
// - Timeout zero leaves the speed-up pin floating and the pump gain follows the gain bit.
// - Timeout one drives the speed-up pin low and forces the 4 mA pump level.
// - Timeout two drives the speed-up pin low and the pump follows the gain bit.
// - Timeout three drives the speed-up pin high and the pump follows the gain bit.
// - Timeout 4 to 4095 starts automatic speed-up with the pin low and the pump at 4 mA.
// - Automatic speed-up lasts exactly the programmed count of events, then the pin floats.
// - When automatic speed-up ends the pump drops to 1 mA.
// - A written timeout takes effect only at the next phase-detector event.
// - The 4-bit test select is the upper pair over the lower pair.
// - Select 0 floats the test pin, 1 drives it high, 2 drives it low.
// - Selects 3 to 5 give digital lock detect open drain: both, RF, IF.
// - Selects 6 to 8 give analog lock detect open drain: both, RF, IF.
// - Selects 9 to 11 give analog lock detect push-pull: both, RF, IF.
// - Selects 12 to 15 give half of IF ref, IF feedback, RF ref, RF feedback.
`include "ifsto_defs.vh"

module ifsto_top #(
  parameter DATA_W = 32
) (
  // clock and reset
  input wire i_sys_clk,
  input wire i_rst_n,
  // register port
  input wire [`IFSTO_ADDR_W-1:0] i_addr,
  input wire [DATA_W-1:0] i_wr_data,
  input wire i_wr_en,
  input wire i_rd_en,
  output reg [DATA_W-1:0] o_rd_data,
  // IF phase-detector event source
  input wire i_if_pfd,
  // lock detect levels
  input wire i_rf_dig_lock,
  input wire i_if_dig_lock,
  input wire i_rf_ana_lock,
  input wire i_if_ana_lock,
  // divider outputs
  input wire i_if_ref_div,
  input wire i_if_fb_div,
  input wire i_rf_ref_div,
  input wire i_rf_fb_div,
  // speed-up pin and pump level
  output reg o_if_speedup_pin_out,
  output reg o_if_speedup_pin_oe,
  output reg o_if_pump_high,
  // test and lock pin
  output reg o_test_lock_pin_out,
  output reg o_test_lock_pin_oe
);

localparam TO_W = `IFSTO_TO_W;

// automatic speed-up states
localparam ST_IDLE = 2'b00;
localparam ST_RUN = 2'b01;
localparam ST_DONE = 2'b10;

////////////////////////////////////////////////////////////////////////
// input synchronisers

wire [8:0] raw_in;
wire [8:0] sync_in;
wire pfd_lvl;
wire rf_dld;
wire if_dld;
wire rf_ald;
wire if_ald;
wire [3:0] div_lvl;

assign raw_in = {i_rf_fb_div, i_rf_ref_div, i_if_fb_div, i_if_ref_div,
                 i_if_ana_lock, i_rf_ana_lock, i_if_dig_lock, i_rf_dig_lock,
                 i_if_pfd};

ifsto_sync #(.WIDTH(9)) u_sync (
  .i_sys_clk(i_sys_clk),
  .i_rst_n(i_rst_n),
  .i_async(raw_in),
  .o_sync(sync_in)
);

assign pfd_lvl = sync_in[0];
assign rf_dld = sync_in[1];
assign if_dld = sync_in[2];
assign rf_ald = sync_in[3];
assign if_ald = sync_in[4];
assign div_lvl = sync_in[8:5];

////////////////////////////////////////////////////////////////////////
// phase-detector event edge

reg pfd_prev;
wire pfd_event;

always @(posedge i_sys_clk) begin
  if (!i_rst_n) begin
    pfd_prev <= 1'b0;
  end else begin
    pfd_prev <= pfd_lvl;
  end
end

assign pfd_event = pfd_lvl & ~pfd_prev;

////////////////////////////////////////////////////////////////////////
// halved divider outputs

wire [3:0] div_half;

genvar gi;
generate
  for (gi = 0; gi < 4; gi = gi + 1) begin : g_halve
    ifsto_halve u_halve (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_level(div_lvl[gi]),
      .o_half(div_half[gi]),
      .o_rise()
    );
  end
endgenerate

////////////////////////////////////////////////////////////////////////
// software registers

reg [TO_W-1:0] to_written;
reg to_pending;
reg pump_gain_sel;
reg [1:0] sel_lo;
reg [1:0] sel_hi;
wire wr_timeout;
wire wr_pump;
wire wr_select;

assign wr_timeout = i_wr_en && (i_addr == `IFSTO_REG_TIMEOUT);
assign wr_pump = i_wr_en && (i_addr == `IFSTO_REG_PUMP);
assign wr_select = i_wr_en && (i_addr == `IFSTO_REG_SELECT);

always @(posedge i_sys_clk) begin
  if (!i_rst_n) begin
    to_written <= `IFSTO_TO_RST;
    pump_gain_sel <= `IFSTO_PUMP_RST;
    sel_lo <= `IFSTO_SEL_RST;
    sel_hi <= `IFSTO_SEL_RST;
  end else begin
    if (wr_timeout) begin
      to_written <= i_wr_data[TO_W-1:0];
    end
    if (wr_pump) begin
      pump_gain_sel <= i_wr_data[`IFSTO_PUMP_GAIN_BIT];
    end
    if (wr_select) begin
      sel_lo <= i_wr_data[`IFSTO_SEL_LO_LSB+1:`IFSTO_SEL_LO_LSB];
      sel_hi <= i_wr_data[`IFSTO_SEL_HI_LSB+1:`IFSTO_SEL_HI_LSB];
    end
  end
end

// pending until event
// a write landing on an event cycle waits for the following event
always @(posedge i_sys_clk) begin
  if (!i_rst_n) begin
    to_pending <= 1'b0;
  end else if (wr_timeout) begin
    to_pending <= 1'b1;
  end else if (pfd_event) begin
    to_pending <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////
// latched timeout and automatic period counter

reg [TO_W-1:0] to_active;
reg [TO_W-1:0] ev_count;
reg [1:0] auto_state;
reg [1:0] next_auto_state;
reg [TO_W-1:0] next_ev_count;
wire latch_now;

assign latch_now = pfd_event && to_pending;

always @* begin
  next_auto_state = auto_state;
  next_ev_count = ev_count;
  if (latch_now) begin
    if (to_written >= `IFSTO_TO_AUTO_MIN) begin
      next_auto_state = ST_RUN;
      next_ev_count = to_written;
    end else begin
      next_auto_state = ST_IDLE;
      next_ev_count = {TO_W{1'b0}};
    end
  end else if (pfd_event) begin
    case (auto_state)
      ST_RUN: begin
        if (ev_count == {{(TO_W-1){1'b0}}, 1'b1}) begin
          next_auto_state = ST_DONE;
          next_ev_count = {TO_W{1'b0}};
        end else begin
          next_ev_count = ev_count - {{(TO_W-1){1'b0}}, 1'b1};
        end
      end
      ST_IDLE: next_auto_state = ST_IDLE;
      ST_DONE: next_auto_state = ST_DONE;
      default: next_auto_state = ST_IDLE;
    endcase
  end
end

always @(posedge i_sys_clk) begin
  if (!i_rst_n) begin
    to_active <= `IFSTO_TO_RST;
    ev_count <= {TO_W{1'b0}};
    auto_state <= ST_IDLE;
  end else begin
    if (latch_now) begin
      to_active <= to_written;
    end
    ev_count <= next_ev_count;
    auto_state <= next_auto_state;
  end
end

////////////////////////////////////////////////////////////////////////
// speed-up pin and pump level

reg next_su_out;
reg next_su_oe;
reg next_pump_high;

// pin driven low with the gain bit unless a code below says otherwise
always @* begin
  next_su_out = 1'b0;
  next_su_oe = 1'b1;
  next_pump_high = pump_gain_sel;
  case (to_active)
    `IFSTO_TO_HIZ: next_su_oe = 1'b0;
    `IFSTO_TO_MANUAL: next_pump_high = 1'b1;
    `IFSTO_TO_GPO_LOW: next_su_out = 1'b0;
    `IFSTO_TO_GPO_HIGH: next_su_out = 1'b1;
    default: begin
      next_su_oe = (auto_state == ST_RUN);
      next_pump_high = (auto_state == ST_RUN);
    end
  endcase
end

always @(posedge i_sys_clk) begin
  if (!i_rst_n) begin
    o_if_speedup_pin_out <= 1'b0;
    o_if_speedup_pin_oe <= 1'b0;
    o_if_pump_high <= 1'b0;
  end else begin
    o_if_speedup_pin_out <= next_su_out;
    o_if_speedup_pin_oe <= next_su_oe;
    o_if_pump_high <= next_pump_high;
  end
end

////////////////////////////////////////////////////////////////////////
// test and lock pin select

wire [3:0] test_output_select;
reg next_tp_out;
reg next_tp_oe;

assign test_output_select = {sel_hi, sel_lo};

// open drain: pulls low while unlocked, released when locked
always @* begin
  next_tp_out = 1'b0;
  next_tp_oe = 1'b1;
  case (test_output_select)
    `IFSTO_MUX_HIZ: next_tp_oe = 1'b0;
    `IFSTO_MUX_HIGH: next_tp_out = 1'b1;
    `IFSTO_MUX_LOW: next_tp_out = 1'b0;
    `IFSTO_MUX_DLD_BOTH: next_tp_oe = ~(rf_dld & if_dld);
    `IFSTO_MUX_DLD_RF: next_tp_oe = ~rf_dld;
    `IFSTO_MUX_DLD_IF: next_tp_oe = ~if_dld;
    `IFSTO_MUX_ALD_OD_BOTH: next_tp_oe = ~(rf_ald & if_ald);
    `IFSTO_MUX_ALD_OD_RF: next_tp_oe = ~rf_ald;
    `IFSTO_MUX_ALD_OD_IF: next_tp_oe = ~if_ald;
    `IFSTO_MUX_ALD_PP_BOTH: next_tp_out = rf_ald & if_ald;
    `IFSTO_MUX_ALD_PP_RF: next_tp_out = rf_ald;
    `IFSTO_MUX_ALD_PP_IF: next_tp_out = if_ald;
    `IFSTO_MUX_IF_REF: next_tp_out = div_half[0];
    `IFSTO_MUX_IF_FB: next_tp_out = div_half[1];
    `IFSTO_MUX_RF_REF: next_tp_out = div_half[2];
    `IFSTO_MUX_RF_FB: next_tp_out = div_half[3];
    default: next_tp_oe = 1'b0;
  endcase
end

always @(posedge i_sys_clk) begin
  if (!i_rst_n) begin
    o_test_lock_pin_out <= 1'b0;
    o_test_lock_pin_oe <= 1'b0;
  end else begin
    o_test_lock_pin_out <= next_tp_out;
    o_test_lock_pin_oe <= next_tp_oe;
  end
end

////////////////////////////////////////////////////////////////////////
// register read-back

reg [DATA_W-1:0] rd_word;

always @* begin
  rd_word = {DATA_W{1'b0}};
  case (i_addr)
    `IFSTO_REG_TIMEOUT: rd_word[TO_W-1:0] = to_written;
    `IFSTO_REG_PUMP: rd_word[`IFSTO_PUMP_GAIN_BIT] = pump_gain_sel;
    `IFSTO_REG_SELECT: begin
      rd_word[`IFSTO_SEL_LO_LSB+1:`IFSTO_SEL_LO_LSB] = sel_lo;
      rd_word[`IFSTO_SEL_HI_LSB+1:`IFSTO_SEL_HI_LSB] = sel_hi;
    end
    `IFSTO_REG_STATUS: begin
      rd_word[`IFSTO_ST_TO_LSB+TO_W-1:`IFSTO_ST_TO_LSB] = to_active;
      rd_word[`IFSTO_ST_PEND] = to_pending;
      rd_word[`IFSTO_ST_RUN] = (auto_state == ST_RUN);
      rd_word[`IFSTO_ST_DONE] = (auto_state == ST_DONE);
      rd_word[`IFSTO_ST_PUMP] = o_if_pump_high;
      rd_word[`IFSTO_ST_PIN_OE] = o_if_speedup_pin_oe;
      rd_word[`IFSTO_ST_PIN_OUT] = o_if_speedup_pin_out;
    end
    default: rd_word = {DATA_W{1'b0}};
  endcase
end

// data valid only in the cycle after the strobe, zero otherwise
always @(posedge i_sys_clk) begin
  if (!i_rst_n) begin
    o_rd_data <= {DATA_W{1'b0}};
  end else if (i_rd_en) begin
    o_rd_data <= rd_word;
  end else begin
    o_rd_data <= {DATA_W{1'b0}};
  end
end

endmodule // ifsto_top

// ### ifsto_partner.sv
// Purpose: far side: phase detector, lock levels, divider outputs
// Assumes: i_fire is a one-cycle request for one event
// Notes: dividers run free, half periods 4, 6, 8 and 10 cycles
module ifsto_partner (
  // clock and requests
  input wire i_sys_clk,
  input wire i_fire,
  input wire [3:0] i_lock,
  // levels toward the block
  output logic o_pfd,
  output logic [3:0] o_lock,
  output logic [3:0] o_div
);
  timeunit 1ns;
  timeprecision 1ps;
  int hold = 0;
  int cnt = 0;
  initial o_pfd = 1'b0;
  initial o_div = 4'h0;
  assign o_lock = i_lock;
  // three cycles high keeps the pulse wider than the two-flop sync needs
  always @(posedge i_sys_clk) begin
    cnt <= cnt + 1;
    if (i_fire) begin
      hold <= 3;
    end else if (hold > 0) begin
      hold <= hold - 1;
    end
    o_pfd <= (hold > 0);
    for (int k = 0; k < 4; k++) begin
      if (cnt % (4 + 2 * k) == 0) begin
        o_div[k] <= !o_div[k];
      end
    end
  end
endmodule // ifsto_partner

// ### ifsto_top_assertions.sv
// Purpose: port-level checks for the speed-up and test pin block
// Assumes: select and gain mirrored from register writes
// Notes: event timing taken from raw input rises
`include "ifsto_defs.vh"
module ifsto_top_assertions #(
  parameter DATA_W = 32
) (
  input wire i_sys_clk, input wire i_rst_n,
  input wire [`IFSTO_ADDR_W-1:0] i_addr,
  input wire [DATA_W-1:0] i_wr_data,
  input wire i_wr_en, input wire i_rd_en,
  input wire [DATA_W-1:0] o_rd_data,
  input wire i_if_pfd,
  input wire i_rf_dig_lock, input wire i_if_dig_lock,
  input wire i_rf_ana_lock, input wire i_if_ana_lock,
  input wire i_if_ref_div, input wire i_if_fb_div,
  input wire i_rf_ref_div, input wire i_rf_fb_div,
  input wire o_if_speedup_pin_out, input wire o_if_speedup_pin_oe,
  input wire o_if_pump_high,
  input wire o_test_lock_pin_out, input wire o_test_lock_pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] sel;
  logic gain;
  logic pfd_q;
  logic [3:0] age;
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      sel <= 4'h0;
      gain <= 1'b0;
      pfd_q <= 1'b0;
      age <= 4'hf;
    end else begin
      if (i_wr_en && i_addr == `IFSTO_REG_SELECT) sel <= i_wr_data[3:0];
      if (i_wr_en && i_addr == `IFSTO_REG_PUMP) gain <= i_wr_data[0];
      pfd_q <= i_if_pfd;
      age <= (i_if_pfd && !pfd_q) ? 4'h0 : (age == 4'hf ? age : age + 4'h1);
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  //////////////////////////////////////////////////////////////////////
  chk_sel_float: assert property ($past(sel) == `IFSTO_MUX_HIZ |-> !o_test_lock_pin_oe)
    else $error("test pin driven while floating");
  chk_sel_high: assert property ($past(sel) == `IFSTO_MUX_HIGH
    |-> o_test_lock_pin_oe && o_test_lock_pin_out)
    else $error("test pin not high");
  chk_sel_low: assert property ($past(sel) == `IFSTO_MUX_LOW
    |-> o_test_lock_pin_oe && !o_test_lock_pin_out)
    else $error("test pin not low");
  chk_od_never_high: assert property ($past(sel) inside {[4'h3:4'h8]}
    |-> !(o_test_lock_pin_oe && o_test_lock_pin_out))
    else $error("open drain drove high");
  chk_pp_drives: assert property ($past(sel) inside {[4'h9:4'hb]} |-> o_test_lock_pin_oe)
    else $error("push-pull lock not driven");
  chk_div_drives: assert property ($past(sel) >= `IFSTO_MUX_IF_REF
    |-> o_test_lock_pin_oe)
    else $error("divider output not driven");
  chk_pin_on_event: assert property ($changed(o_if_speedup_pin_oe) |-> age < 4'h8)
    else $error("speed-up pin moved without event");
  chk_high_gpo_gain: assert property (o_if_speedup_pin_oe && o_if_speedup_pin_out
    && $stable(gain) && $past(gain, 2) == gain && $past(gain, 3) == gain
    |-> o_if_pump_high == gain)
    else $error("pump ignores gain bit");
  chk_rd_quiet: assert property (!$past(i_rd_en) |-> o_rd_data == '0)
    else $error("read data outside its cycle");
  cover property ($past(sel) == `IFSTO_MUX_ALD_PP_RF && o_test_lock_pin_out);
  cover property ($fell(o_if_speedup_pin_oe) ##1 !o_if_pump_high);
  cover property (o_if_speedup_pin_oe && o_if_speedup_pin_out);
endmodule // ifsto_top_assertions
bind ifsto_top ifsto_top_assertions #(.DATA_W(DATA_W)) u_chk (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr_data(i_wr_data),
  .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .i_if_pfd(i_if_pfd),
  .i_rf_dig_lock(i_rf_dig_lock), .i_if_dig_lock(i_if_dig_lock),
  .i_rf_ana_lock(i_rf_ana_lock), .i_if_ana_lock(i_if_ana_lock),
  .i_if_ref_div(i_if_ref_div), .i_if_fb_div(i_if_fb_div),
  .i_rf_ref_div(i_rf_ref_div), .i_rf_fb_div(i_rf_fb_div),
  .o_if_speedup_pin_out(o_if_speedup_pin_out), .o_if_speedup_pin_oe(o_if_speedup_pin_oe),
  .o_if_pump_high(o_if_pump_high), .o_test_lock_pin_out(o_test_lock_pin_out),
  .o_test_lock_pin_oe(o_test_lock_pin_oe));

// ### tb.sv
// Purpose: self-checking bench against an integer model
// Assumes: one event per ev call, settled ten cycles later
// Notes: floating speed-up level is masked, only driven level counts
`include "ifsto_defs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wr_data = 32'h0;
  logic i_wr_en = 1'b0;
  logic i_rd_en = 1'b0;
  logic fire = 1'b0;
  logic [3:0] lock = 4'h0;
  logic last;
  wire [31:0] o_rd_data;
  wire pfd, so, soe, ph, to, toe;
  wire [3:0] lk, dv;
  int errors = 0;
  int n_compared = 0;
  int seed = 93084;
  int tow = 0, pend = 0, lat = 0, cnt = 0, run = 0, done = 0, gain = 0, n, k, e;
  always #2.5 i_sys_clk = ~i_sys_clk;
  ifsto_partner u_far (.i_sys_clk(i_sys_clk), .i_fire(fire), .i_lock(lock), .o_pfd(pfd),
    .o_lock(lk), .o_div(dv));
  ifsto_top dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
    .i_if_pfd(pfd), .i_rf_dig_lock(lk[3]), .i_if_dig_lock(lk[2]), .i_rf_ana_lock(lk[1]),
    .i_if_ana_lock(lk[0]), .i_if_ref_div(dv[0]), .i_if_fb_div(dv[1]), .i_rf_ref_div(dv[2]),
    .i_rf_fb_div(dv[3]), .o_if_speedup_pin_out(so), .o_if_speedup_pin_oe(soe),
    .o_if_pump_high(ph), .o_test_lock_pin_out(to), .o_test_lock_pin_oe(toe));
  //////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      errors++;
      $display("Error at %0t: expected %h got %h", $time, x, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wr_data <= d;
    i_wr_en <= 1'b1;
    @(posedge i_sys_clk);
    i_wr_en <= 1'b0;
    if (a == `IFSTO_REG_TIMEOUT) {tow, pend} = {d[11:0], 32'd1};
    if (a == `IFSTO_REG_PUMP) gain = d[0];
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd_en <= 1'b1;
    @(posedge i_sys_clk);
    i_rd_en <= 1'b0;
    #1 cmp(x, o_rd_data & m);
  endtask
  // one event, then the model steps
  task automatic ev();
    @(posedge i_sys_clk);
    fire <= 1'b1;
    @(posedge i_sys_clk);
    fire <= 1'b0;
    repeat (8) @(posedge i_sys_clk);
    if (pend) begin
      {lat, pend, cnt, done} = {tow, 32'd0, tow, 32'd0};
      run = lat >= 4;
    end else if (run) begin
      cnt--;
      if (cnt == 0) {run, done} = 64'd1;
    end
  endtask
  function automatic logic [31:0] st();
    logic oe, pu;
    oe = run || (lat >= 1 && lat <= 3);
    pu = run || lat == 1 || (lat < 4 && gain);
    return {oe, pu, done[0], run[0], pend[0], lat[11:0]};
  endfunction
  task automatic pins();
    #1 cmp({st() >> 15, 1'b0} | (lat == 3 && !run), {soe, ph, soe & so});
  endtask
  function automatic logic [1:0] tp(input int s);
    logic d, a;
    d = s == 3 ? lk[3] & lk[2] : (s == 4 ? lk[3] : lk[2]);
    a = (s == 6 || s == 9) ? lk[1] & lk[0] : ((s == 7 || s == 10) ? lk[1] : lk[0]);
    case (s)
      0: tp = 2'b00;
      1: tp = 2'b11;
      2: tp = 2'b10;
      3, 4, 5: tp = {!d, 1'b0};
      6, 7, 8: tp = {!a, 1'b0};
      default: tp = {1'b1, a};
    endcase
  endfunction
  //////////////////////////////////////////////////////////////////////
  initial begin
    #450us;
    errors++;
    end_sim();
  end
  initial begin
    repeat (20) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    for (int a = 0; a < 20; a += 4) rd(a, 32'h0, 32'hffffffff);
    wr(8'h10, 32'hffffffff);
    wr(`IFSTO_REG_STATUS, 32'hffffffff);
    rd(`IFSTO_REG_STATUS, 32'h0, 32'hffffffff);
    for (int i = 0; i < 8; i++) begin
      wr(`IFSTO_REG_PUMP, i / 4);
      wr(`IFSTO_REG_TIMEOUT, i % 4);
      pins();
      rd(`IFSTO_REG_STATUS, st(), 32'h1ffff);
      ev();
      pins();
      rd(`IFSTO_REG_STATUS, st(), 32'h1ffff);
    end
    for (int t = 0; t < 3; t++) begin
      n = t == 0 ? 4 : (t == 1 ? 4 + {$random(seed)} % 60 : 4095);
      wr(`IFSTO_REG_PUMP, 0);
      wr(`IFSTO_REG_TIMEOUT, n);
      ev();
      pins();
      repeat (n - 1) ev();
      pins();
      ev();
      pins();
      wr(`IFSTO_REG_PUMP, 1);
      ev();
      pins();
      rd(`IFSTO_REG_STATUS, st(), 32'h1ffff);
    end
    for (int i = 0; i < 32; i++) begin
      @(posedge i_sys_clk);
      lock <= $random(seed);
      wr(`IFSTO_REG_SELECT, {i[3:2], i[1:0]});
      repeat (6) @(posedge i_sys_clk);
      if (i % 16 < 12) begin
        #1 cmp(tp(i % 16), {toe, toe & to});
      end else begin
        #1 last = to;
        k = 0;
        repeat (240) begin
          @(posedge i_sys_clk);
          #1 k += (to !== last);
          last = to;
        end
        e = 240 / (8 + 4 * (i % 16 - 12));
        cmp({e, 1'b1}, {(k - e + 1) inside {[0:2]} ? e : k, toe});
      end
    end
    end_sim();
  end
endmodule // tb
